// >>> asb_defines.svh
// opcodes, register bit positions, buffer geometry and timing counts
`ifndef ASB_DEFINES_SVH
`define ASB_DEFINES_SVH
`define ASB_OP_STANDBY_IMM      8'hE0
`define ASB_OP_STANDBY_IMM_ALT  8'h94
`define ASB_OP_WRITE_BUF        8'hE8
`define ASB_OP_WRITE_BUF_DMA    8'hEB
`define ASB_OP_READ_BUF         8'hE4
`define ASB_ERR_ABORT_BIT       2
`define ASB_ST_BUSY_BIT         7
`define ASB_ST_READY_BIT        6
`define ASB_ST_FAULT_BIT        5
`define ASB_ST_SEEK_DONE_BIT    4
`define ASB_ST_DRQ_BIT          3
`define ASB_ST_CORR_BIT         2
`define ASB_ST_ERR_BIT          0
`define ASB_STATUS_RESET        8'h50
`define ASB_ERROR_RESET         8'h00
`define ASB_SECTOR_WORDS        256
`define ASB_SPIN_DOWN_NS        2000
`define ASB_SPIN_UP_NS          5000
`define ASB_CLK_PERIOD_NS       10
`define ASB_SPIN_DOWN_CYC       (`ASB_SPIN_DOWN_NS / `ASB_CLK_PERIOD_NS)
`define ASB_SPIN_UP_CYC         (`ASB_SPIN_UP_NS / `ASB_CLK_PERIOD_NS)
`endif

// >>> asb_pkg.sv
// types shared by the standby and buffer-write command block
package asb_pkg;
  typedef enum logic [2:0] {
    ASB_IDLE,
    ASB_SPIN_DOWN,
    ASB_SPIN_UP,
    ASB_XFER,
    ASB_READ,
    ASB_DONE
  } asb_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } asb_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } asb_word_t;
endpackage

// >>> asb_cmd_block.sv
// command decode and execution for standby immediate and buffer writes
`include "asb_defines.svh"

// Behaviour
// RULE_01: E0h or 94h means standby immediate
// RULE_02: standby entered at once, no timer wait
// RULE_03: spindle stops; register interface stays live
// RULE_04: already stopped spindle skips spin-down
// RULE_05: standby accepts commands; media commands spin up
// RULE_06: standby immediate keeps stored timeout value
// RULE_07: extended power enabled enters Standby_Z
// RULE_08: E8h means programmed buffer write
// RULE_09: programmed write stores one sector in buffer
// RULE_10: buffer data moves as 16-bit words
// RULE_11: buffer read returns last written sector
// RULE_12: EBh means DMA buffer write
// RULE_13: DMA write stores one sector in buffer
// RULE_14: error register reports only abort flag
// RULE_15: completion status bits, seek done for standby
// RULE_16: idle timeout enters standby, access restarts
module asb_cmd_block
  import asb_pkg::*;
#(
  parameter int SECTOR_WORDS  = `ASB_SECTOR_WORDS,
  parameter int SPIN_DOWN_CYC = `ASB_SPIN_DOWN_CYC,
  parameter int SPIN_UP_CYC   = `ASB_SPIN_UP_CYC
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire asb_cmd_t    cmd_in,
  input  wire asb_word_t   pio_word_in,
  input  wire asb_word_t   dma_word_in,
  input  wire logic        data_rd_in,
  input  wire logic        host_access_in,
  input  wire logic        epc_enable_in,
  input  wire logic        timeout_set_in,
  input  wire logic [31:0] timeout_cyc_in,
  output logic [15:0]      data_out,
  output logic [7:0]       command_error_flags_out,
  output logic [7:0]       command_status_flags_out,
  output logic             dma_req_out,
  output logic             spindle_run_out,
  output logic             standby_out,
  output logic             standby_z_out,
  output logic [31:0]      timeout_value_out
);
  localparam int AW = $clog2(SECTOR_WORDS);
  localparam int CW = 32;
  // counters are 32 bits, wide enough for any int spin time

  // command kind held for the running command
  localparam logic [1:0] KIND_NONE    = 2'h0;
  localparam logic [1:0] KIND_STANDBY = 2'h1;
  localparam logic [1:0] KIND_PIO     = 2'h2;
  localparam logic [1:0] KIND_DMA     = 2'h3;

  initial
  begin
    if (SECTOR_WORDS < 2)
      $error("asb_cmd_block: sector needs at least two words");
    if (SPIN_DOWN_CYC < 1)
      $error("asb_cmd_block: spin-down time must be at least one cycle");
    if (SPIN_UP_CYC < 1)
      $error("asb_cmd_block: spin-up time must be at least one cycle");
  end

  function automatic logic [1:0] decode_op(input logic [7:0] op);
    // 0 none, 1 standby, 2 pio write, 3 dma write
    case (op)
      `ASB_OP_STANDBY_IMM, `ASB_OP_STANDBY_IMM_ALT: decode_op = KIND_STANDBY; // [RULE_01]
      `ASB_OP_WRITE_BUF:                          decode_op = KIND_PIO; // [RULE_08]
      `ASB_OP_WRITE_BUF_DMA:                      decode_op = KIND_DMA; // [RULE_12]
      default:                                    decode_op = KIND_NONE;
    endcase
  endfunction

  // no command in flight: the command register is open and the idle timer may run
  function automatic logic is_quiet(input asb_state_t st);
    case (st)
      ASB_IDLE, ASB_DONE: is_quiet = 1'b1;
      default:            is_quiet = 1'b0;
    endcase
  endfunction

  // ending status: ready always, seek done only after standby, error bit clear
  function automatic logic [7:0] done_status(input logic [1:0] kind);
    logic [7:0] st;
    st                        = 8'h00;
    st[`ASB_ST_READY_BIT]     = 1'b1; // [RULE_15]
    st[`ASB_ST_SEEK_DONE_BIT] = kind == KIND_STANDBY; // [RULE_15]
    st[`ASB_ST_ERR_BIT]       = 1'b0; // [RULE_14]
    done_status               = st;
  endfunction

  asb_state_t      state;
  logic [1:0]      cur_kind;
  logic [CW-1:0]   wait_cnt;
  logic [AW-1:0]   ptr;
  logic [15:0]     sector_mem [SECTOR_WORDS];
  logic [CW-1:0]   idle_cnt;
  logic [1:0]      new_kind;
  logic            is_read;
  logic            accept;
  logic            word_take;
  logic [15:0]     word_data;
  // decoded conditions shared by several processes
  logic            quiet;
  logic            standby_req;
  logic            last_word;
  logic            spin_down_done;
  logic            spin_up_done;
  logic            idle_reload;
  logic            timer_expired;

  assign new_kind       = decode_op(cmd_in.opcode);
  assign is_read        = cmd_in.opcode == `ASB_OP_READ_BUF;
  assign quiet          = is_quiet(state);
  // commands are only taken while not busy; the interface stays live in standby
  assign accept         = cmd_in.valid && quiet; // [RULE_03] [RULE_05]
  assign standby_req    = accept && new_kind == KIND_STANDBY; // [RULE_01] [RULE_02]
  assign word_take      = state == ASB_XFER && // [RULE_10]
                          (cur_kind == KIND_PIO ? pio_word_in.valid : dma_word_in.valid);
  assign word_data      = cur_kind == KIND_PIO ? pio_word_in.data : dma_word_in.data;
  // the final word closes the transfer in the cycle in which it is taken
  assign last_word      = word_take && ptr == AW'(SECTOR_WORDS - 1);
  assign spin_down_done = state == ASB_SPIN_DOWN && wait_cnt == CW'(SPIN_DOWN_CYC - 1);
  assign spin_up_done   = state == ASB_SPIN_UP && wait_cnt == CW'(SPIN_UP_CYC - 1);
  // any host activity restarts the countdown, and so does a stopped spindle
  assign idle_reload    = host_access_in || cmd_in.valid || timeout_set_in || !spindle_run_out;
  // expiry needs a quiet cycle: an access in the same cycle wins and restarts the timer
  assign timer_expired  = quiet && !idle_reload && idle_cnt == 32'h1; // [RULE_16]

  // command sequencer
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state    <= ASB_IDLE;
      cur_kind <= 2'h0;
      wait_cnt <= '0;
    end
    else
    begin
      case (state)
        ASB_IDLE, ASB_DONE:
        begin
          if (standby_req)
          begin
            cur_kind <= 2'h1;
            wait_cnt <= '0;
            // spindle already stopped: nothing to wind down
            state    <= spindle_run_out ? ASB_SPIN_DOWN : ASB_DONE; // [RULE_02] [RULE_04]
          end
          else if (accept && (new_kind != 2'h0 || is_read))
          begin
            cur_kind <= is_read ? 2'h0 : new_kind;
            wait_cnt <= '0;
            // buffer lives in the controller, so no media spin-up is needed here
            state    <= is_read ? ASB_READ : ASB_XFER; // [RULE_09] [RULE_13]
          end
          else if (accept)
          begin
            cur_kind <= 2'h0;
            wait_cnt <= '0;
            // any other command is taken to need the media
            state    <= spindle_run_out ? ASB_DONE : ASB_SPIN_UP; // [RULE_05]
          end
        end
        ASB_SPIN_DOWN:
        begin
          wait_cnt <= wait_cnt + 1'b1;
          if (spin_down_done)
            state <= ASB_DONE;
        end
        ASB_SPIN_UP:
        begin
          wait_cnt <= wait_cnt + 1'b1;
          if (spin_up_done)
            state <= ASB_DONE;
        end
        ASB_XFER:
        begin
          if (last_word)
            state <= ASB_DONE; // [RULE_09]
        end
        ASB_READ:
        // reads leave the buffer untouched, so a second read returns the same sector
        begin
          if (data_rd_in && ptr == AW'(SECTOR_WORDS - 1))
            state <= ASB_DONE;
        end
        default:
          state <= ASB_IDLE;
      endcase
    end
  end

  // word pointer restarts at zero so reads and writes share one sector region
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ptr <= '0;
    else if (accept)
      ptr <= '0; // [RULE_11]
    else if (word_take || (state == ASB_READ && data_rd_in))
      ptr <= ptr + 1'b1;
  end

  // sector buffer; no reset, contents are defined by the last write
  always_ff @(posedge clk_sys_in)
  begin
    if (word_take)
      sector_mem[ptr] <= word_data; // [RULE_09] [RULE_13] [RULE_11]
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      data_out <= 16'h0000;
    // the read word trails the pointer by one cycle, so reads are at most every other cycle
    else if (state == ASB_READ)
      data_out <= sector_mem[ptr]; // [RULE_11]
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      dma_req_out <= 1'b0;
    else
      dma_req_out <= state == ASB_XFER && cur_kind == 2'h3 &&
                     !last_word; // [RULE_13]
  end

  // power state: spindle, standby, extended standby
  // timer expiry leaves the sequencer alone; the last ending status keeps standing
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      spindle_run_out <= 1'b1;
      standby_out     <= 1'b0;
      standby_z_out   <= 1'b0;
    end
    else if (standby_req || timer_expired)
    begin
      spindle_run_out <= 1'b0; // [RULE_03] [RULE_16]
      standby_out     <= 1'b1; // [RULE_02]
      standby_z_out   <= epc_enable_in; // [RULE_07]
    end
    else if (spin_up_done)
    begin
      spindle_run_out <= 1'b1; // [RULE_05]
      standby_out     <= 1'b0;
      standby_z_out   <= 1'b0;
    end
  end

  // stored timeout only changes on its own setter, never on standby immediate
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      timeout_value_out <= 32'h0;
    else if (timeout_set_in)
      timeout_value_out <= timeout_cyc_in; // [RULE_06]
  end

  // idle countdown: zero means disabled or expired
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      idle_cnt <= 32'h0;
    else if (idle_reload)
      idle_cnt <= timeout_set_in ? timeout_cyc_in : timeout_value_out; // [RULE_16]
    else if (idle_cnt != 32'h0 && quiet)
      idle_cnt <= idle_cnt - 1'b1; // [RULE_16]
  end

  // completion status and error flags
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      command_status_flags_out <= `ASB_STATUS_RESET;
      command_error_flags_out  <= `ASB_ERROR_RESET;
    end
    else if (accept)
    begin
      command_status_flags_out <= 8'h80;
      command_error_flags_out  <= 8'h00;
    end
    else if (state == ASB_XFER || state == ASB_READ)
    begin
      command_status_flags_out <= 8'h00;
      command_status_flags_out[`ASB_ST_DRQ_BIT] <= 1'b1;
    end
    // ending status is written once, then stands until the next accepted command
    else if (state == ASB_DONE && command_status_flags_out[`ASB_ST_BUSY_BIT] |
             command_status_flags_out[`ASB_ST_DRQ_BIT])
    begin
      command_status_flags_out <= done_status(cur_kind); // [RULE_14] [RULE_15]
      command_error_flags_out <= 8'h00; // only abort may ever be set [RULE_14]
    end
  end
endmodule

// >>> asb_cmd_block_asserts.sv
// port checks for the command block
module asb_cmd_block_asserts
  import asb_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire asb_cmd_t    cmd_in,
  input wire logic        epc_enable_in,
  input wire logic        timeout_set_in,
  input wire logic [7:0]  command_error_flags_out,
  input wire logic [7:0]  command_status_flags_out,
  input wire logic        dma_req_out,
  input wire logic        spindle_run_out,
  input wire logic        standby_out,
  input wire logic        standby_z_out,
  input wire logic [31:0] timeout_value_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // commands seen while busy or moving data are dropped, save in the first done cycle, when the status still lags the sequencer
  wire logic [7:0] st = command_status_flags_out;
  wire logic       tk = cmd_in.valid && !st[7] && !st[3];
  wire logic       sb = tk && (cmd_in.opcode == 8'hE0 || cmd_in.opcode == 8'h94);
  a_error_abort_only:
    assert property (command_error_flags_out == 8'h00) else $error("error reg");
  a_status_clean:
    assert property (!st[5] && !st[2]) else $error("fault bits");
  a_standby_now:
    assert property (sb |=> standby_out && !spindle_run_out) else $error("standby late");
  a_timeout_kept:
    assert property (sb && !timeout_set_in |=> $stable(timeout_value_out)) else $error("tmo");
  a_standby_z_on:
    assert property (sb && epc_enable_in |=> standby_z_out) else $error("standby_z");
  a_spin_skip:
    assert property (sb && !spindle_run_out |=> ##[0:1] st == 8'h50) else $error("slow");
  a_pio_request:
    assert property (tk && cmd_in.opcode == 8'hE8 && spindle_run_out |=> st == 8'h80 ##1 st == 8'h08)
      else $error("no drq");
  a_dma_request:
    assert property (tk && cmd_in.opcode == 8'hEB && spindle_run_out |=> ##1 dma_req_out)
      else $error("no dma req");
endmodule

bind asb_cmd_block asb_cmd_block_asserts u_asserts (.*);

// >>> asb_host_model.sv
// host model: issues commands and hands over data words
module asb_host_model
  import asb_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic dma_req_in,
  output asb_cmd_t  cmd_out,
  output asb_word_t pio_out,
  output asb_word_t dma_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_out = '0;
    pio_out = '0;
    dma_out = '0;
  end
  task automatic issue(input logic [7:0] op);
    @(posedge clk_sys_in);
    cmd_out <= '{1'b1, op};
    @(posedge clk_sys_in);
    cmd_out <= '{1'b0, ~op};
  endtask
  task automatic send_word(input logic dma, input logic [15:0] d);
    for (int i = 0; i < 20 && dma && dma_req_in !== 1'b1; i++)
      @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    pio_out <= '{!dma, d};
    dma_out <= '{dma, d};
    @(posedge clk_sys_in);
    pio_out <= '{1'b0, ~d};
    dma_out <= '{1'b0, ~d};
  endtask
endmodule

// >>> asb_cmd_block_tb_top.sv
// self-checking bench for the command block
module asb_cmd_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asb_pkg::*;
  localparam int SW = 8;
  logic        clk_sys_in = 1'b0, reset_n_in = 1'b0, epc_enable_in = 1'b0;
  logic        data_rd_in = 1'b0, host_access_in = 1'b0, timeout_set_in = 1'b0;
  logic        dma_req_out, spindle_run_out, standby_out, standby_z_out;
  logic [7:0]  command_error_flags_out, command_status_flags_out;
  logic [15:0] data_out;
  logic [31:0] timeout_cyc_in = 32'h0, timeout_value_out;
  asb_cmd_t    cmd_in;
  asb_word_t   pio_word_in, dma_word_in;
  int          n_errors = 0, total_checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  asb_host_model host (.clk_sys_in(clk_sys_in), .dma_req_in(dma_req_out), .cmd_out(cmd_in),
    .pio_out(pio_word_in), .dma_out(dma_word_in));
  asb_cmd_block #(.SECTOR_WORDS(SW), .SPIN_DOWN_CYC(4), .SPIN_UP_CYC(8)) uut (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [7:0] exp, input int lim);
    @(negedge clk_sys_in);
    for (int i = 0; i < lim && command_status_flags_out !== exp; i++)
      @(negedge clk_sys_in);
    check("status", command_status_flags_out, exp);
  endtask
  task automatic t_write(input logic [7:0] op, input logic dma, input logic [15:0] base);
    host.issue(op);
    wait_st(8'h08, 4);
    for (int i = 0; i < SW; i++)
      host.send_word(dma, base + 16'(i));
    wait_st(8'h40, 3);
    check("error", command_error_flags_out, 8'h00);
    host.send_word(1'b0, 16'hFFFF);
    host.issue(8'hE4);
    wait_st(8'h08, 8);
    for (int i = 0; i < SW; i++)
    begin
      check("data", data_out, base + 16'(i));
      @(posedge clk_sys_in);
      data_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      data_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      @(negedge clk_sys_in);
    end
  endtask
  task automatic t_standby();
    @(posedge clk_sys_in);
    {timeout_set_in, timeout_cyc_in} <= {1'b1, 32'd40};
    @(posedge clk_sys_in);
    {timeout_set_in, timeout_cyc_in} <= {1'b0, ~32'd40};
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_sys_in);
      epc_enable_in <= k[0];
      host.issue(k[0] ? 8'h94 : 8'hE0);
      wait_st(8'h50, k[0] ? 1 : 8);
      check("power", {standby_out, spindle_run_out, standby_z_out}, {2'b10, k[0]});
      check("timeout", timeout_value_out, 32'd40);
    end
    host.issue(8'hC8);
    wait_st(8'h40, 12);
    check("spin up", {standby_out, spindle_run_out}, 2'b01);
    repeat (30) @(negedge clk_sys_in);
    check("idle early", {standby_out, spindle_run_out}, 2'b01);
    repeat (14) @(negedge clk_sys_in);
    check("idle expiry", {standby_out, spindle_run_out}, 2'b10);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #50us;
    n_errors++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_write(8'hE8, 1'b0, 16'hA500);
    t_write(8'hEB, 1'b1, 16'h5A00);
    t_standby();
    final_report();
  end
endmodule
